// ---- verif/decode_stage_model.sv ----
/*
  Decode stage model: presents queued requests back to back, idle zeros.
  Assumes the bench queues requests only after reset is released.
*/
`timescale 1ns/1ps
`default_nettype none

module decode_stage_model (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  output var  operand_addr_pkg::decode_req_t req_o
);
  import operand_addr_pkg::*;

  decode_req_t pend_q [$];

  // Keeps each pointer on its own side of the X and Y split at bit 13
  function automatic prefetch_operand_t fence(input prefetch_operand_t p);
    if (p.ptr_idx[3:2] == 2'b10) p.ptr_val[13] = p.ptr_idx[1];
    return p;
  endfunction

  task automatic put(input decode_req_t r);
    r.pf_a = fence(r.pf_a);
    r.pf_b = fence(r.pf_b);
    pend_q.push_back(r);
  endtask

  always @(posedge mclk_i) begin
    if (!rst_n_i || pend_q.size() == 0) req_o <= '0;
    else req_o <= pend_q.pop_front();
  end

endmodule

`default_nettype wire

// ---- verif/operand_addr_chk.sv ----
/*
  Port checks of the operand addressing decoder.
  Assumes one clock domain and a bind from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none

module operand_addr_chk (
  input wire logic                          mclk_i,
  input wire logic                          rst_n_i,
  input wire operand_addr_pkg::decode_req_t req_i,
  input wire operand_addr_pkg::decode_rsp_t rsp_o
);
  import operand_addr_pkg::*;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic is_mac;
  assign is_mac = req_i.valid && req_i.cls == CLS_MAC;

  // ==========================================================================
  // Prefetch sequences
  // ==========================================================================
  sequence s_mac_both;
    is_mac && req_i.pf_a.ptr_idx == X_PREFETCH_POINTER_A && req_i.pf_a.mode == MAC_POST2
      && req_i.pf_b.ptr_idx == Y_PREFETCH_POINTER_A && req_i.pf_b.mode == MAC_POST4;
  endsequence

  sequence s_both_written;
    rsp_o.legal && rsp_o.x.wb && rsp_o.y.wb
      && rsp_o.x.wb_val == $past(req_i.pf_a.ptr_val) + 16'h0002
      && rsp_o.y.wb_val == $past(req_i.pf_b.ptr_val) + 16'h0004;
  endsequence

  sequence s_plain_pair;
    is_mac && req_i.pf_a.ptr_idx == X_PREFETCH_POINTER_A && req_i.pf_a.mode == MAC_INDIRECT
      && req_i.pf_b.ptr_idx == Y_PREFETCH_POINTER_B && req_i.pf_b.mode == MAC_INDIRECT;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_answer_follows: assert property (
    req_i.valid && req_i.cls != CLS_NONE |=> rsp_o.valid)
    else $error("answer missing one cycle after request");
  a_idle_quiet: assert property (
    !(req_i.valid && req_i.cls != CLS_NONE) |=> !rsp_o.valid)
    else $error("answer without request");
  a_mode_subset: assert property (
    req_i.valid && req_i.cls == CLS_MOVE && !req_i.allowed_modes[req_i.src.mode]
      |=> !rsp_o.legal)
    else $error("disallowed move mode accepted");
  a_branch_literal: assert property (
    req_i.valid && req_i.cls == CLS_BRANCH
      |=> rsp_o.legal && rsp_o.branch_offset == $past(req_i.literal))
    else $error("branch literal wrong");
  a_interrupt_disable_instruction_literal: assert property (
    req_i.valid && req_i.cls == CLS_INTERRUPT_DISABLE_INSTRUCTION |=> rsp_o.interrupt_disable_instruction_count == $past(req_i.literal[13:0]))
    else $error("interrupt disable literal wrong");
  a_nop_empty: assert property (
    req_i.valid && req_i.cls == CLS_NOP |=> rsp_o.legal && rsp_o.no_operand)
    else $error("no operation flag missing");
  a_pointer_set: assert property (
    is_mac && req_i.pf_a.mode != MAC_NONE && req_i.pf_a.ptr_idx[3:2] != 2'b10
      |=> !rsp_o.legal)
    else $error("prefetch pointer outside set accepted");
  a_indexed_limit: assert property (
    is_mac && req_i.pf_a.mode == MAC_INDEXED && !req_i.pf_a.ptr_idx[0] |=> !rsp_o.legal)
    else $error("indexed prefetch on wrong pointer accepted");
  a_mac_modes: assert property (
    is_mac && req_i.pf_a.mode inside {MAC_RSVD6, MAC_RSVD7} |=> !rsp_o.legal)
    else $error("reserved prefetch mode accepted");
  a_space_routing: assert property (
    s_plain_pair |=> rsp_o.x.ea == $past(req_i.pf_a.ptr_val) && rsp_o.y.space_y
      && rsp_o.y.ea == $past(req_i.pf_b.ptr_val) && !rsp_o.x.space_y)
    else $error("prefetch pointer routed to wrong generator");
  a_dual_modify: assert property (
    s_mac_both |=> s_both_written)
    else $error("both prefetch modifies not in one cycle");

endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
/*
  Self-checking bench of the operand addressing decoder.
  Assumes the decode stage model and the checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;
  import operand_addr_pkg::*;

  logic        mclk_i;
  logic        rst_n_i;
  decode_req_t req;
  decode_rsp_t rsp;
  decode_rsp_t got [$];
  int          fails;
  int          checked;
  int          cycles;

  decode_stage_model i_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_o(req));
  operand_addressing_modes i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end

  task automatic collect(input int n);
    got.delete();
    @(posedge mclk_i);
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      got.push_back(rsp);
    end
  endtask

  function automatic decode_req_t mv(input instr_class_t c, input move_mode_t m);
    decode_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.cls = c;
    r.allowed_modes = 8'hff;
    r.src = '{m, 1'b0, 4'h2, 16'h1000};
    r.offset_val = 16'h0020;
    r.literal = 16'h12ab;
    return r;
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_move_modes();
    logic [15:0] e [8] = '{16'h1000, 16'h1000, 16'h1000, 16'h1002,
                           16'h1020, 16'h22ab, 16'h00ab, 16'h12ab};
    decode_req_t r;
    for (int m = 0; m < 8; m++) i_model.put(mv(CLS_MOVE, move_mode_t'(m)));
    i_model.put(mv(CLS_ACCUM, MV_INDEXED));
    r = mv(CLS_MOVE, MV_PRE_MOD);
    r.src.dec = 1'b1;
    i_model.put(r);
    collect(10);
    for (int m = 0; m < 8; m++) begin
      `CHK("move legal", 1'b1, got[m].src.legal)
      `CHK("move value", e[m], (m inside {[1:5]}) ? got[m].src.ea : got[m].src.imm)
    end
    `CHK("post writeback", 16'h1002, got[2].src.wb_val)
    `CHK("accum indexed", 16'h1020, got[8].src.ea)
    `CHK("accum legal", 1'b1, got[8].legal)
    `CHK("pre decrement", 16'h0ffe, got[9].src.ea)
    `CHK("post index", 4'h2, got[2].src.wb_idx)
  endtask

  task automatic t_shared_offset();
    decode_req_t r;
    r = mv(CLS_MOVE, MV_INDEXED);
    r.offset_register_field = 4'h5;
    r.dst = '{MV_LIT_OFFSET, 1'b0, 4'h3, 16'h3000};
    r.literal = 16'h0010;
    i_model.put(r);
    collect(1);
    `CHK("shared field", 4'h5, got[0].offset_register_field)
    `CHK("src offset", 1'b1, got[0].src.uses_offset)
    `CHK("dst no offset", 1'b0, got[0].dst.uses_offset)
    `CHK("dst address", 16'h3010, got[0].dst.ea)
    `CHK("src address", 16'h1020, got[0].src.ea)
  endtask

  task automatic t_subset();
    decode_req_t r;
    r = mv(CLS_MOVE, MV_REG_DIRECT);
    r.allowed_modes = 8'hfe;
    i_model.put(r);
    i_model.put(mv(CLS_ORDINARY, MV_INDEXED));
    i_model.put(mv(CLS_ORDINARY, MV_LIT8));
    i_model.put(mv(CLS_NONE, MV_LIT8));
    collect(4);
    `CHK("subset refused", 1'b0, got[0].legal)
    `CHK("ordinary indexed", 1'b0, got[1].legal)
    `CHK("ordinary literal", 1'b1, got[2].legal)
    `CHK("no class", 1'b0, got[3].valid)
  endtask

  task automatic t_mac(input prefetch_operand_t a, input prefetch_operand_t b,
                       input logic ok);
    decode_req_t       r;
    prefetch_operand_t x;
    prefetch_operand_t y;
    logic [15:0]       st;
    r = '0;
    r.valid = 1'b1;
    r.cls = CLS_MAC;
    r.pf_a = a;
    r.pf_b = b;
    r.pf_offset_val = 16'h0040;
    i_model.put(r);
    collect(1);
    `CHK("mac legal", ok, got[0].legal)
    if (ok) begin
      x = (a.ptr_idx < 4'ha) ? a : b;
      y = (a.ptr_idx < 4'ha) ? b : a;
      st = (x.mode == MAC_POST2) ? 16'h2 : (x.mode == MAC_POST4) ? 16'h4 :
           (x.mode == MAC_POST6) ? 16'h6 : 16'h0;
      `CHK("x address", x.ptr_val + ((x.mode == MAC_INDEXED) ? 16'h40 : 16'h0), got[0].x.ea)
      `CHK("y address", y.ptr_val + ((y.mode == MAC_INDEXED) ? 16'h40 : 16'h0), got[0].y.ea)
      `CHK("y space", 1'b1, got[0].y.space_y)
      `CHK("x modify", x.ptr_val + st, got[0].x.wb ? got[0].x.wb_val : x.ptr_val)
      `CHK("both active", 1'b1, got[0].x.active && got[0].y.active)
      `CHK("x index", x.ptr_idx, got[0].x.wb_idx)
    end
  endtask

  task automatic t_literals();
    decode_req_t r;
    r = mv(CLS_BRANCH, MV_REG_DIRECT);
    r.literal = 16'h8001;
    i_model.put(r);
    r.cls = CLS_INTERRUPT_DISABLE_INSTRUCTION;
    r.literal = 16'hffff;
    i_model.put(r);
    i_model.put(mv(CLS_NOP, MV_REG_DIRECT));
    i_model.put(mv(CLS_IMPLIED, MV_REG_DIRECT));
    collect(4);
    `CHK("branch offset", 16'h8001, got[0].branch_offset)
    `CHK("disable count", 14'h3fff, got[1].interrupt_disable_instruction_count)
    `CHK("class echo", CLS_INTERRUPT_DISABLE_INSTRUCTION, got[1].cls)
    `CHK("no operand", 1'b1, got[2].no_operand)
    `CHK("implied", 1'b1, got[3].implied_operand)
  endtask

  initial begin
    fails = 0;
    checked = 0;
    cycles = 0;
    rst_n_i = 1'b0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    `CHK("reset answer", '0, rsp)
    t_move_modes();
    t_shared_offset();
    t_subset();
    t_mac('{MAC_INDIRECT, 4'h8, 16'h1000}, '{MAC_INDIRECT, 4'hb, 16'h2000}, 1'b1);
    t_mac('{MAC_POST2, 4'h8, 16'h1000}, '{MAC_POST4, 4'ha, 16'h2000}, 1'b1);
    t_mac('{MAC_POST6, 4'h9, 16'h1100}, '{MAC_INDEXED, 4'hb, 16'h2100}, 1'b1);
    t_mac('{MAC_INDEXED, 4'h9, 16'h1200}, '{MAC_POST2, 4'ha, 16'h2200}, 1'b1);
    t_mac('{MAC_INDIRECT, 4'h7, 16'h1000}, '{MAC_INDIRECT, 4'hb, 16'h2000}, 1'b0);
    t_mac('{MAC_INDEXED, 4'h8, 16'h1000}, '{MAC_INDIRECT, 4'ha, 16'h2000}, 1'b0);
    t_mac('{MAC_RSVD6, 4'h9, 16'h1000}, '{MAC_INDIRECT, 4'ha, 16'h2000}, 1'b0);
    t_mac('{MAC_INDIRECT, 4'h8, 16'h1000}, '{MAC_INDIRECT, 4'h9, 16'h1000}, 1'b0);
    t_literals();
    close_out();
  end

endmodule

bind operand_addressing_modes operand_addr_chk i_chk (
  .mclk_i (mclk_i),
  .rst_n_i(rst_n_i),
  .req_i  (req_i),
  .rsp_o  (rsp_o)
);

`default_nettype wire

// ---- verilog/move_operand.sv ----
/*
  Effective address and legality of one move or accumulator operand.
  Assumes the pointer and offset register contents are valid with the request.
*/
`timescale 1ns/1ps
`default_nettype none

module move_operand (
  input  wire operand_addr_pkg::move_operand_t       op_i,
  input  wire logic [operand_addr_pkg::NUM_MODES-1:0] allowed_i,
  input  wire logic [operand_addr_pkg::DATA_W-1:0]    offset_val_i,
  input  wire logic [operand_addr_pkg::DATA_W-1:0]    literal_i,
  output var  operand_addr_pkg::move_result_t        res_o
);
  import operand_addr_pkg::*;

  logic [DATA_W-1:0] stepped;

  // ==========================================================================
  // Address arithmetic
  // ==========================================================================
  always_comb begin
    stepped = op_i.dec ? op_i.ptr_val - WORD_STEP : op_i.ptr_val + WORD_STEP;
    res_o = '0;
    res_o.legal = allowed_i[op_i.mode];
    case (op_i.mode)
      MV_REG_DIRECT: begin
        res_o.imm = op_i.ptr_val;
      end
      MV_REG_INDIRECT: begin
        res_o.has_addr = 1'b1;
        res_o.ea = op_i.ptr_val;
      end
      MV_POST_MOD: begin
        res_o.has_addr = 1'b1;
        res_o.ea = op_i.ptr_val;
        res_o.wb = 1'b1;
        res_o.wb_val = stepped;
      end
      MV_PRE_MOD: begin
        res_o.has_addr = 1'b1;
        res_o.ea = stepped;
        res_o.wb = 1'b1;
        res_o.wb_val = stepped;
      end
      MV_INDEXED: begin
        res_o.has_addr = 1'b1;
        res_o.uses_offset = 1'b1;
        res_o.ea = op_i.ptr_val + offset_val_i;
      end
      MV_LIT_OFFSET: begin
        res_o.has_addr = 1'b1;
        res_o.ea = op_i.ptr_val + literal_i;
      end
      MV_LIT8: begin
        res_o.imm = {{(DATA_W-SHORT_LIT_W){1'b0}}, literal_i[SHORT_LIT_W-1:0]};
      end
      MV_LIT16: begin
        res_o.imm = literal_i;
      end
      default: begin
        res_o.legal = 1'b0;
      end
    endcase
    res_o.wb_idx = res_o.wb ? op_i.ptr_idx : '0;
  end

endmodule

`default_nettype wire

// ---- verilog/operand_addr_pkg.sv ----
/*
  Shared types and constants for the operand addressing decoder: instruction
  classes, operand mode encodings, pointer register numbers, modify steps and
  the request and answer carriers.
  Assumes the decode stage supplies register contents along with each request.
*/
`default_nettype none

package operand_addr_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int DATA_W         = 16;
  localparam int REG_IDX_W      = 4;
  localparam int OFFSET_FIELD_W = 4;
  localparam int BRANCH_LIT_W   = 16;
  localparam int INTERRUPT_DISABLE_INSTRUCTION_LIT_W     = 14;
  localparam int SHORT_LIT_W    = 8;
  localparam int NUM_MODES      = 8;
  localparam int NUM_PREFETCH   = 2;

  // ==========================================================================
  // Prefetch pointer registers
  // ==========================================================================
  localparam logic [REG_IDX_W-1:0] X_PREFETCH_POINTER_A = 4'h8;
  localparam logic [REG_IDX_W-1:0] X_PREFETCH_POINTER_B = 4'h9;
  localparam logic [REG_IDX_W-1:0] Y_PREFETCH_POINTER_A = 4'ha;
  localparam logic [REG_IDX_W-1:0] Y_PREFETCH_POINTER_B = 4'hb;

  // ==========================================================================
  // Modify steps
  // ==========================================================================
  localparam logic [DATA_W-1:0] WORD_STEP  = 16'h0002;
  localparam logic [DATA_W-1:0] POST_STEP2 = 16'h0002;
  localparam logic [DATA_W-1:0] POST_STEP4 = 16'h0004;
  localparam logic [DATA_W-1:0] POST_STEP6 = 16'h0006;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [3:0] {
    CLS_NONE,
    CLS_MOVE,
    CLS_ACCUM,
    CLS_MAC,
    CLS_BRANCH,
    CLS_INTERRUPT_DISABLE_INSTRUCTION,
    CLS_IMPLIED,
    CLS_NOP,
    CLS_ORDINARY
  } instr_class_t;

  typedef enum logic [2:0] {
    MV_REG_DIRECT,
    MV_REG_INDIRECT,
    MV_POST_MOD,
    MV_PRE_MOD,
    MV_INDEXED,
    MV_LIT_OFFSET,
    MV_LIT8,
    MV_LIT16
  } move_mode_t;

  typedef enum logic [2:0] {
    MAC_NONE,
    MAC_INDIRECT,
    MAC_POST2,
    MAC_POST4,
    MAC_POST6,
    MAC_INDEXED,
    MAC_RSVD6,
    MAC_RSVD7
  } mac_mode_t;

  // Mode masks, bit position equals the move_mode_t code
  localparam logic [NUM_MODES-1:0] ORDINARY_MODE_MASK = 8'h4f;
  localparam logic [NUM_MODES-1:0] MOVE_MODE_MASK     = 8'hff;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    move_mode_t           mode;
    logic                 dec;
    logic [REG_IDX_W-1:0] ptr_idx;
    logic [DATA_W-1:0]    ptr_val;
  } move_operand_t;

  typedef struct packed {
    mac_mode_t            mode;
    logic [REG_IDX_W-1:0] ptr_idx;
    logic [DATA_W-1:0]    ptr_val;
  } prefetch_operand_t;

  typedef struct packed {
    logic                      valid;
    instr_class_t              cls;
    logic [NUM_MODES-1:0]      allowed_modes;
    move_operand_t             src;
    move_operand_t             dst;
    logic [OFFSET_FIELD_W-1:0] offset_register_field;
    logic [DATA_W-1:0]         offset_val;
    logic [DATA_W-1:0]         literal;
    prefetch_operand_t         pf_a;
    prefetch_operand_t         pf_b;
    logic [DATA_W-1:0]         pf_offset_val;
  } decode_req_t;

  typedef struct packed {
    logic                 legal;
    logic                 has_addr;
    logic                 uses_offset;
    logic [DATA_W-1:0]    ea;
    logic [DATA_W-1:0]    imm;
    logic                 wb;
    logic [REG_IDX_W-1:0] wb_idx;
    logic [DATA_W-1:0]    wb_val;
  } move_result_t;

  typedef struct packed {
    logic                 active;
    logic                 in_set;
    logic                 space_y;
    logic                 mode_ok;
    logic [DATA_W-1:0]    ea;
    logic                 wb;
    logic [REG_IDX_W-1:0] wb_idx;
    logic [DATA_W-1:0]    wb_val;
  } prefetch_result_t;

  typedef struct packed {
    logic                      valid;
    logic                      legal;
    instr_class_t              cls;
    move_result_t              src;
    move_result_t              dst;
    logic [OFFSET_FIELD_W-1:0] offset_register_field;
    prefetch_result_t          x;
    prefetch_result_t          y;
    logic [BRANCH_LIT_W-1:0]   branch_offset;
    logic [INTERRUPT_DISABLE_INSTRUCTION_LIT_W-1:0]     interrupt_disable_instruction_count;
    logic                      implied_operand;
    logic                      no_operand;
  } decode_rsp_t;

endpackage

`default_nettype wire

// ---- verilog/operand_addressing_modes.sv ----
/*
  Operand addressing decoder of the core: checks the effective address modes
  of each instruction class, computes move operand addresses, routes the two
  multiply-accumulate prefetch pointers to the X and Y address generators and
  extracts the literal fields of branch and interrupt-disable instructions.
  Assumes the decode stage presents one request per cycle with the register
  contents already read, and applies the answer one cycle later.
*/
// Behaviour
// - Move and accumulator instructions also accept pointer plus offset register addressing.
// - Move source and destination modes independent, sharing one 4-bit offset field.
// - Move and accumulator classes support eight operand modes including both literals.
// - Multiply-accumulate class uses a reduced mode set for walking pointer tables.
// - Prefetch source pointers must be working registers eight through eleven.
// - Registers eight and nine go to X generator, ten and eleven to Y.
// - Prefetch indexed addressing only on register nine and register eleven.
// - Prefetch modes: indirect, post-modify by 2, 4, 6, and indexed only.
// - Each move or accumulator instruction may allow only a subset of modes.
// - Branch destination comes from a 16-bit signed literal in the instruction.
// - Interrupt-disable instruction carries a 14-bit unsigned literal operand.
// - Some opcodes imply their operand location; no-operation carries no operands.
`timescale 1ns/1ps
`default_nettype none

module operand_addressing_modes (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire operand_addr_pkg::decode_req_t req_i,
  output var  operand_addr_pkg::decode_rsp_t rsp_o
);
  import operand_addr_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    decode_rsp_t rsp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ==========================================================================
  // Mode masks per class
  // ==========================================================================
  logic [NUM_MODES-1:0] class_mask;
  logic [NUM_MODES-1:0] allowed_mask;
  logic                 is_move;
  logic                 is_accum;
  logic                 is_ordinary;

  always_comb begin
    is_move     = (req_i.cls == CLS_MOVE);
    is_accum    = (req_i.cls == CLS_ACCUM);
    is_ordinary = (req_i.cls == CLS_ORDINARY);
    case (req_i.cls)
      CLS_MOVE: begin
        class_mask = MOVE_MODE_MASK;
      end
      CLS_ACCUM: begin
        class_mask = MOVE_MODE_MASK;
      end
      CLS_ORDINARY: begin
        class_mask = ORDINARY_MODE_MASK;
      end
      default: begin
        class_mask = '0;
      end
    endcase
    allowed_mask = class_mask & req_i.allowed_modes;
  end

  // ==========================================================================
  // Move operands: source and destination decoded independently
  // ==========================================================================
  move_operand_t mv_op  [2];
  move_result_t  mv_res [2];

  assign mv_op[0] = req_i.src;
  assign mv_op[1] = req_i.dst;

  // ==========================================================================
  // Prefetch operands
  // ==========================================================================
  prefetch_operand_t pf_op  [NUM_PREFETCH];
  prefetch_result_t  pf_res [NUM_PREFETCH];

  assign pf_op[0] = req_i.pf_a;
  assign pf_op[1] = req_i.pf_b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_operand
      // Both instances see the same offset register contents
      move_operand u_move (
        .op_i         (mv_op[gi]),
        .allowed_i    (allowed_mask),
        .offset_val_i (req_i.offset_val),
        .literal_i    (req_i.literal),
        .res_o        (mv_res[gi])
      );
      // Both prefetch generators work in parallel in the same cycle
      prefetch_agu u_prefetch (
        .op_i         (pf_op[gi]),
        .offset_val_i (req_i.pf_offset_val),
        .res_o        (pf_res[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Prefetch routing and checks
  // ==========================================================================
  logic             a_ok;
  logic             b_ok;
  logic             space_clash;
  logic             mac_legal;
  prefetch_result_t x_sel;
  prefetch_result_t y_sel;

  always_comb begin
    a_ok = !pf_res[0].active || (pf_res[0].in_set && pf_res[0].mode_ok);
    b_ok = !pf_res[1].active || (pf_res[1].in_set && pf_res[1].mode_ok);
    // Each generator takes at most one pointer per instruction
    space_clash = pf_res[0].active && pf_res[1].active &&
                  (pf_res[0].space_y == pf_res[1].space_y);
    mac_legal = a_ok && b_ok && !space_clash;
    x_sel = '0;
    y_sel = '0;
    // The address space of each pointer is trusted to hold its address
    if (pf_res[0].active && pf_res[0].in_set) begin
      if (pf_res[0].space_y) begin
        y_sel = pf_res[0];
      end else begin
        x_sel = pf_res[0];
      end
    end
    if (pf_res[1].active && pf_res[1].in_set) begin
      if (pf_res[1].space_y) begin
        y_sel = pf_res[1];
      end else begin
        x_sel = pf_res[1];
      end
    end
  end

  // ==========================================================================
  // Move legality
  // ==========================================================================
  logic mv_legal;
  logic offset_shared;

  always_comb begin
    // Source and destination modes are checked each on its own
    mv_legal = mv_res[0].legal && (!is_move || mv_res[1].legal);
    offset_shared = mv_res[0].uses_offset || (is_move && mv_res[1].uses_offset);
  end

  // ==========================================================================
  // Next answer
  // ==========================================================================
  always_comb begin
    state_nxt = '0;
    state_nxt.rsp.valid = req_i.valid && (req_i.cls != CLS_NONE);
    state_nxt.rsp.cls   = req_i.cls;
    if (req_i.valid) begin
      case (req_i.cls)
        CLS_MOVE: begin
          state_nxt.rsp.legal = mv_legal;
          state_nxt.rsp.src   = mv_res[0];
          state_nxt.rsp.dst   = mv_res[1];
          if (offset_shared) begin
            state_nxt.rsp.offset_register_field = req_i.offset_register_field;
          end
        end
        CLS_ACCUM: begin
          state_nxt.rsp.legal = mv_legal;
          state_nxt.rsp.src   = mv_res[0];
          if (offset_shared) begin
            state_nxt.rsp.offset_register_field = req_i.offset_register_field;
          end
        end
        CLS_ORDINARY: begin
          state_nxt.rsp.legal = mv_legal && is_ordinary;
          state_nxt.rsp.src   = mv_res[0];
        end
        CLS_MAC: begin
          state_nxt.rsp.legal = mac_legal;
          if (mac_legal) begin
            state_nxt.rsp.x = x_sel;
            state_nxt.rsp.y = y_sel;
          end
        end
        CLS_BRANCH: begin
          state_nxt.rsp.legal = 1'b1;
          state_nxt.rsp.branch_offset = req_i.literal[BRANCH_LIT_W-1:0];
        end
        CLS_INTERRUPT_DISABLE_INSTRUCTION: begin
          state_nxt.rsp.legal = 1'b1;
          state_nxt.rsp.interrupt_disable_instruction_count = req_i.literal[INTERRUPT_DISABLE_INSTRUCTION_LIT_W-1:0];
        end
        CLS_IMPLIED: begin
          state_nxt.rsp.legal = 1'b1;
          state_nxt.rsp.implied_operand = 1'b1;
        end
        CLS_NOP: begin
          state_nxt.rsp.legal = 1'b1;
          state_nxt.rsp.no_operand = 1'b1;
        end
        default: begin
          state_nxt.rsp.legal = 1'b0;
        end
      endcase
      // Nothing is written back from an illegal instruction
      if (!state_nxt.rsp.legal) begin
        state_nxt.rsp.src = '0;
        state_nxt.rsp.dst = '0;
        state_nxt.rsp.x   = '0;
        state_nxt.rsp.y   = '0;
        state_nxt.rsp.offset_register_field = '0;
      end
      if (is_accum) begin
        state_nxt.rsp.dst = '0;
      end
    end
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rsp_o = state_r.rsp;

endmodule

`default_nettype wire

// ---- verilog/prefetch_agu.sv ----
/*
  One prefetch operand of a multiply-accumulate instruction: pointer set check,
  address space selection, mode check, effective address and post-modify.
  Assumes the pointer and offset register contents are valid with the request.
*/
`timescale 1ns/1ps
`default_nettype none

module prefetch_agu (
  input  wire operand_addr_pkg::prefetch_operand_t op_i,
  input  wire logic [operand_addr_pkg::DATA_W-1:0]  offset_val_i,
  output var  operand_addr_pkg::prefetch_result_t  res_o
);
  import operand_addr_pkg::*;

  logic x_reg;
  logic y_reg;
  logic idx_reg;

  // ==========================================================================
  // Pointer check and address generation
  // ==========================================================================
  always_comb begin
    x_reg   = (op_i.ptr_idx == X_PREFETCH_POINTER_A) || (op_i.ptr_idx == X_PREFETCH_POINTER_B);
    y_reg   = (op_i.ptr_idx == Y_PREFETCH_POINTER_A) || (op_i.ptr_idx == Y_PREFETCH_POINTER_B);
    idx_reg = (op_i.ptr_idx == X_PREFETCH_POINTER_B) || (op_i.ptr_idx == Y_PREFETCH_POINTER_B);
    res_o = '0;
    res_o.active  = (op_i.mode != MAC_NONE);
    res_o.in_set  = x_reg || y_reg;
    res_o.space_y = y_reg;
    res_o.ea      = op_i.ptr_val;
    res_o.wb_idx  = op_i.ptr_idx;
    case (op_i.mode)
      MAC_NONE: begin
        res_o.mode_ok = 1'b1;
      end
      MAC_INDIRECT: begin
        res_o.mode_ok = 1'b1;
      end
      MAC_POST2: begin
        res_o.mode_ok = 1'b1;
        res_o.wb = 1'b1;
        res_o.wb_val = op_i.ptr_val + POST_STEP2;
      end
      MAC_POST4: begin
        res_o.mode_ok = 1'b1;
        res_o.wb = 1'b1;
        res_o.wb_val = op_i.ptr_val + POST_STEP4;
      end
      MAC_POST6: begin
        res_o.mode_ok = 1'b1;
        res_o.wb = 1'b1;
        res_o.wb_val = op_i.ptr_val + POST_STEP6;
      end
      MAC_INDEXED: begin
        res_o.mode_ok = idx_reg;
        res_o.ea = op_i.ptr_val + offset_val_i;
      end
      default: begin
        res_o.mode_ok = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire
